// *** src/erbc_pkg.sv ***
package erbc_pkg;

    // clock rate of the supervision logic
    localparam int CLK_MHZ = 125;

    // sequencer states
    typedef enum logic [2:0] {
        ST_INIT = 3'h0,
        ST_RESTORE = 3'h1,
        ST_RUN = 3'h2,
        ST_SAVE = 3'h3,
        ST_REC_HOLD = 3'h4,
        ST_REC_BOOT = 3'h5,
        ST_REC_END = 3'h6
    } erbc_state_type;

    // probe usage modes, as set by the configuration store
    typedef enum logic [2:0] {
        USE_NORM_INIT = 3'h0,
        USE_NORM_NOINIT = 3'h1,
        USE_RAM_NOINIT = 3'h2,
        USE_RAM_INIT = 3'h3,
        USE_DISABLED = 3'h4
    } erbc_usage_type;

    // boot configuration encoding that selects external boot
    localparam logic [1:0] BOOT_CFG_EXTERNAL = 2'h2;

    // green flash half period in milliseconds
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * CLK_MHZ * 1000;

    // reset held after programming before the normal boot, in nanoseconds
    localparam int REC_END_NS = 10000;
    localparam int REC_END_CYCLES = (REC_END_NS * CLK_MHZ + 999) / 1000;

    // reset values of the registered outputs
    localparam logic RST_LED = 1'b0;
    localparam logic RST_ECU_RESET_OE = 1'b1;
    localparam logic RST_WRITE_PROTECT = 1'b1;

endpackage : erbc_pkg

// *** src/erbc_sync.sv ***
`timescale 1ns/1ps
// two-stage synchroniser for a bundle of asynchronous levels
module erbc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule : erbc_sync

// *** src/erbc_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// - red lit when ECU on or tool ready
// - after supply loss restore backup into pages
// - green steady after restore until new data
// - green flashes in any RAM adapter mode
// - green off once pages may differ
// - yellow lit while fast link established
// - recovery starts holding MCU reset during load
// - recovery drives boot lines to external boot
// - strobe driven low when recovery releases reset
// - after programming reassert reset, release drives
// - sense ECU supply and report ECU off
// - enter power save when tool disconnected
// - write protect memories while MCU in reset
// - reset source chosen by reset-out option
// - hold ECU reset in save and initialisation
// - ECU reset on tool command or fault
// - reset-out option defaults to disabled
module erbc_top
    import erbc_pkg::*;
#(
    parameter int FLASH_HALF = FLASH_HALF_CYCLES,
    parameter int REC_END = REC_END_CYCLES,
    parameter logic USE_RESET_OUT_DEFAULT = 1'b0
) (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic ECU_SUPPLY_ON,
    input wire logic PROBE_SUPPLY_LOW,
    input wire logic TOOL_CONNECTED,
    input wire logic LINK_UP,
    input wire logic ECU_RESET_LINE_IN,
    input wire logic MCU_RESET_OUT_SENSE_N,
    input wire logic USE_RESET_OUT,
    input wire logic USE_RESET_OUT_VALID,
    input wire logic [2:0] USAGE_MODE,
    input wire logic INIT_DONE,
    input wire logic RESTORE_DONE,
    input wire logic CAL_WRITE,
    input wire logic TOOL_RESET_REQ,
    input wire logic PROBE_FAULT,
    input wire logic RECOVERY_START,
    input wire logic BOOT_CODE_LOADED,
    input wire logic PROGRAM_DONE,
    output logic ECU_RESET_LINE_OUT,
    output logic ECU_RESET_LINE_OE,
    output logic [1:0] BOOT_CONFIG_LINES_OUT,
    output logic BOOT_CONFIG_LINES_OE,
    output logic RESET_CONFIG_STROBE_OUT,
    output logic RESET_CONFIG_STROBE_OE,
    output logic WRITE_PROTECT,
    output logic ECU_OFF,
    output logic POWER_SAVE,
    output logic RESTORE_REQ,
    output logic RECOVERY_ACTIVE,
    output logic LED_RED,
    output logic LED_GREEN,
    output logic LED_YELLOW
);

    // any usage mode other than initialised normal mode is a RAM adapter mode
    function automatic logic ram_adapter(input logic [2:0] mode);
        ram_adapter = (mode != USE_NORM_INIT);
    endfunction : ram_adapter

    // modes in which a supply loss triggers the backup copy
    function automatic logic restore_enabled(input logic [2:0] mode);
        restore_enabled = (mode == USE_NORM_INIT) || (mode == USE_RAM_INIT);
    endfunction : restore_enabled

    // states in which the ECU is held in reset by the sequencer
    function automatic logic holds_reset(input erbc_state_type st);
        holds_reset = (st == ST_INIT) || (st == ST_RESTORE) || (st == ST_SAVE)
            || (st == ST_REC_HOLD) || (st == ST_REC_END);
    endfunction : holds_reset

    logic [5:0] sync_q;
    logic ecu_on_s;
    logic probe_low_s;
    logic tool_s;
    logic link_s;
    logic ecu_rst_n_s;
    logic rso_n_s;
    logic use_rso;
    logic mcu_in_reset;
    erbc_state_type state;
    erbc_state_type next_state;
    logic pf_seen;
    logic pf_now;
    logic [31:0] rec_cnt;
    logic [31:0] blink_cnt;
    logic blink_en;
    logic blink_phase;
    logic restored;
    logic next_restored;
    // all checks sample on the rising clock and sleep through reset
    default clocking chk_cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);

    // all pin levels pass two flops; reset lines idle inactive high
    erbc_sync #(.W(6), .INIT(6'h30)) u_sync (
        .clk(MCLK),
        .rst_n(RSTN),
        .d({MCU_RESET_OUT_SENSE_N, ECU_RESET_LINE_IN, LINK_UP, TOOL_CONNECTED,
            PROBE_SUPPLY_LOW, ECU_SUPPLY_ON}),
        .q(sync_q)
    );

    assign ecu_on_s = sync_q[0];
    assign probe_low_s = sync_q[1];
    assign tool_s = sync_q[2];
    assign link_s = sync_q[3];
    assign ecu_rst_n_s = sync_q[4];
    assign rso_n_s = sync_q[5];

    // reset-out option: default until configuration is valid
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            use_rso <= 1'b0;
        end else if (USE_RESET_OUT_VALID) begin
            use_rso <= USE_RESET_OUT;
        end else begin
            use_rso <= USE_RESET_OUT_DEFAULT;
        end
    end

    // pick the reset source the option names
    assign mcu_in_reset = use_rso ? !rso_n_s : !ecu_rst_n_s;

    // write protect follows the sensed MCU reset state
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            WRITE_PROTECT <= RST_WRITE_PROTECT;
        end else begin
            WRITE_PROTECT <= mcu_in_reset;
        end
    end

    // ECU off report and power save status
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ECU_OFF <= 1'b1;
            POWER_SAVE <= 1'b0;
        end else begin
            ECU_OFF <= !ecu_on_s;
            POWER_SAVE <= (next_state == ST_SAVE);
        end
    end

    // power fail latch, caught only while initialising after release
    assign pf_now = pf_seen || probe_low_s;

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            pf_seen <= 1'b0;
        end else if (state == ST_INIT) begin
            pf_seen <= pf_now;
        end else begin
            pf_seen <= 1'b0;
        end
    end

    // sequencer next state; tool loss overrides everything
    always_comb begin
        next_state = state;
        case (state)
            ST_INIT: begin
                if (INIT_DONE) begin
                    if (pf_now && restore_enabled(USAGE_MODE)) begin
                        next_state = ST_RESTORE;
                    end else begin
                        next_state = ST_RUN;
                    end
                end
            end
            ST_RESTORE: if (RESTORE_DONE) begin
                next_state = ST_RUN;
            end
            // recovery needs the reset-out sense to see the MCU itself
            ST_RUN: if (RECOVERY_START && use_rso) begin
                next_state = ST_REC_HOLD;
            end
            ST_SAVE: if (tool_s) begin
                next_state = ST_INIT;
            end
            ST_REC_HOLD: if (BOOT_CODE_LOADED) begin
                next_state = ST_REC_BOOT;
            end
            ST_REC_BOOT: if (PROGRAM_DONE) begin
                next_state = ST_REC_END;
            end
            ST_REC_END: if (rec_cnt == 32'h0) begin
                next_state = ST_RUN;
            end
            default: next_state = ST_INIT;
        endcase
        if (!tool_s && state != ST_SAVE) begin
            next_state = ST_SAVE;
        end
    end

    // sequencer state register
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= ST_INIT;
        end else begin
            state <= next_state;
        end
    end

    // reset hold time after programming, before the normal boot
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            rec_cnt <= 32'h0;
        end else if (state != ST_REC_END) begin
            rec_cnt <= 32'(REC_END - 1);
        end else if (rec_cnt != 32'h0) begin
            rec_cnt <= rec_cnt - 32'h1;
        end
    end

    // one pulse to the copy engine as the restore begins
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            RESTORE_REQ <= 1'b0;
        end else begin
            RESTORE_REQ <= (next_state == ST_RESTORE) && (state != ST_RESTORE);
        end
    end

    // ECU reset: open drain, only ever pulled low
    assign ECU_RESET_LINE_OUT = 1'b0;

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ECU_RESET_LINE_OE <= RST_ECU_RESET_OE;
        end else begin
            ECU_RESET_LINE_OE <= holds_reset(next_state)
                || TOOL_RESET_REQ || PROBE_FAULT;
        end
    end

    // boot configuration and strobe drive, released outside recovery
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            BOOT_CONFIG_LINES_OUT <= 2'h0;
            BOOT_CONFIG_LINES_OE <= 1'b0;
            RESET_CONFIG_STROBE_OUT <= 1'b1;
            RESET_CONFIG_STROBE_OE <= 1'b0;
            RECOVERY_ACTIVE <= 1'b0;
        end else begin
            // kept driven across the reset release so the MCU samples it
            BOOT_CONFIG_LINES_OE <= (next_state == ST_REC_HOLD) || (next_state == ST_REC_BOOT);
            BOOT_CONFIG_LINES_OUT <= BOOT_CFG_EXTERNAL;
            RESET_CONFIG_STROBE_OE <= (next_state == ST_REC_HOLD) || (next_state == ST_REC_BOOT);
            RESET_CONFIG_STROBE_OUT <= 1'b0;
            RECOVERY_ACTIVE <= (next_state == ST_REC_HOLD) || (next_state == ST_REC_BOOT)
                || (next_state == ST_REC_END);
        end
    end

    // flash divider: one-cycle enable every half period
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            blink_cnt <= 32'h0;
            blink_en <= 1'b0;
        end else if (blink_cnt == 32'(FLASH_HALF - 1)) begin
            blink_cnt <= 32'h0;
            blink_en <= 1'b1;
        end else begin
            blink_cnt <= blink_cnt + 32'h1;
            blink_en <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            blink_phase <= 1'b0;
        end else if (blink_en) begin
            blink_phase <= !blink_phase;
        end
    end

    // restored data flag: set by the restore, cleared by new data; set wins
    always_comb begin
        next_restored = restored;
        if (CAL_WRITE) begin
            next_restored = 1'b0;
        end
        if (RESTORE_DONE && state == ST_RESTORE) begin
            next_restored = 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            restored <= 1'b0;
        end else begin
            restored <= next_restored;
        end
    end

    // status LEDs
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            LED_RED <= RST_LED;
            LED_GREEN <= RST_LED;
            LED_YELLOW <= RST_LED;
        end else begin
            LED_RED <= ecu_on_s || (tool_s && link_s);
            if (ram_adapter(USAGE_MODE)) begin
                LED_GREEN <= blink_phase;
            end else begin
                LED_GREEN <= next_restored;
            end
            LED_YELLOW <= link_s;
        end
    end

    // checks; reset OE is registered, so the release check looks at last cycle's override inputs
    red_led_on_a: assert property (ecu_on_s |=> LED_RED) else $error("red LED not lit with ECU on");
    restore_start_a: assert property (state == ST_INIT && INIT_DONE && tool_s && pf_now
        && restore_enabled(USAGE_MODE) |=> state == ST_RESTORE && RESTORE_REQ ##1 !RESTORE_REQ)
        else $error("restore not started after supply loss");
    green_steady_a: assert property (state == ST_RESTORE && RESTORE_DONE && tool_s
        && !ram_adapter(USAGE_MODE) |=> LED_GREEN) else $error("green LED not lit after restore");
    green_flash_a: assert property ($rose(blink_phase) && ram_adapter(USAGE_MODE) |=> LED_GREEN)
        else $error("green LED not flashing in adapter mode");
    green_off_a: assert property (CAL_WRITE && !RESTORE_DONE && !ram_adapter(USAGE_MODE) |=> !LED_GREEN)
        else $error("green LED still lit after new data");
    yellow_link_a: assert property (link_s != LED_YELLOW |=> LED_YELLOW == $past(link_s))
        else $error("yellow LED does not follow link");
    rec_hold_a: assert property (state == ST_REC_HOLD |-> ECU_RESET_LINE_OE && BOOT_CONFIG_LINES_OE
        && BOOT_CONFIG_LINES_OUT == BOOT_CFG_EXTERNAL) else $error("recovery load without reset or boot drive");
    rec_release_a: assert property (state == ST_REC_BOOT && !$past(TOOL_RESET_REQ)
        && !$past(PROBE_FAULT) |-> !ECU_RESET_LINE_OE && RESET_CONFIG_STROBE_OE && !RESET_CONFIG_STROBE_OUT)
        else $error("strobe not low at recovery release");
    rec_revert_a: assert property (state == ST_REC_BOOT && PROGRAM_DONE && tool_s
        |=> (ECU_RESET_LINE_OE && !BOOT_CONFIG_LINES_OE && !RESET_CONFIG_STROBE_OE) [*3])
        else $error("drive not reverted after programming");
    ecu_off_a: assert property (!ecu_on_s |=> ECU_OFF) else $error("ECU off not reported");
    save_enter_a: assert property (!tool_s |=> state == ST_SAVE && POWER_SAVE && ECU_RESET_LINE_OE)
        else $error("power save not entered without tool");
    wp_source_a: assert property (use_rso && !rso_n_s && $stable(use_rso) |=> WRITE_PROTECT)
        else $error("writes open while MCU in reset");
    wp_line_a: assert property (!use_rso && ecu_rst_n_s |=> !WRITE_PROTECT)
        else $error("wrong reset source for write protect");
    init_hold_a: assert property (state == ST_INIT |-> ECU_RESET_LINE_OE)
        else $error("ECU released during initialisation");
    fault_reset_a: assert property (PROBE_FAULT || TOOL_RESET_REQ |=> ECU_RESET_LINE_OE)
        else $error("ECU reset not forced");
    open_drain_a: assert property (ECU_RESET_LINE_OE |-> !ECU_RESET_LINE_OUT)
        else $error("ECU reset driven high");
    // main scenarios
    restore_seen_c: cover property (state == ST_RESTORE ##[1:50] state == ST_RUN);
    recovery_done_c: cover property (state == ST_REC_BOOT ##1 state == ST_REC_END);
    save_exit_c: cover property (state == ST_SAVE ##1 state == ST_INIT);

endmodule : erbc_top

// *** dv/erbc_ecu_model.sv ***
`timescale 1ns/1ps
// behavioural model of the ecu side: reset wire, boot strap pins, mcu boot latch
module erbc_ecu_model
    import erbc_pkg::*;
#(
    parameter logic [1:0] PLL_MODE = 2'h1
) (
    input wire logic reset_oe,
    input wire logic reset_drive,
    input wire logic boot_oe,
    input wire logic [1:0] boot_drive,
    input wire logic strobe_oe,
    input wire logic strobe_drive,
    input wire logic ecu_hold,
    input wire logic mcu_int_reset,
    output logic reset_wire,
    output logic reset_out_sense_n,
    output logic [1:0] latched_boot,
    output logic [1:0] pll_mode,
    output logic probe_chip_select_a_n
);
    logic [1:0] boot_pins;
    logic strobe_pin;

    // open-drain reset wire with pull-up, ecu may pull it too
    assign reset_wire = ((reset_oe && !reset_drive) || ecu_hold) ? 1'b0 : 1'b1;
    // weak pulls only, so the probe always wins while it drives
    assign boot_pins = boot_oe ? boot_drive : 2'h0;
    assign strobe_pin = strobe_oe ? strobe_drive : 1'b1;
    // mcu reset-out follows the wire or its own internal reset
    assign reset_out_sense_n = reset_wire && !mcu_int_reset;
    // ecu drives the pll mode pins itself, the probe never does
    assign pll_mode = PLL_MODE;

    // mcu samples its strap pins on reset release; strobe high keeps ecu config
    initial latched_boot = 2'h0;
    always @(posedge reset_wire) begin
        latched_boot <= strobe_pin ? 2'h0 : boot_pins;
    end

    // primary select routed only to the probe while booting externally
    assign probe_chip_select_a_n = !(reset_wire && latched_boot == BOOT_CFG_EXTERNAL);
endmodule : erbc_ecu_model

// *** dv/erbc_top_bench.sv ***
`timescale 1ns/1ps
module erbc_top_bench;
    import erbc_pkg::*;
    logic mclk, rstn, ecu_supply_on, probe_supply_low, tool_connected, link_up, use_reset_out, use_reset_out_valid;
    logic [2:0] usage_mode;
    logic init_done, restore_done, cal_write, tool_reset_req, probe_fault, recovery_start, boot_code_loaded;
    logic program_done, ecu_hold, mcu_int_reset, reset_wire, reset_out_sense_n, reset_drive, reset_oe, boot_oe;
    logic strobe_drive, strobe_oe, write_protect, ecu_off, power_save, restore_req, recovery_active;
    logic led_red, led_green, led_yellow, prev, cs_n;
    logic [1:0] boot_drive, latched_boot, pll_mode;
    int num_errors, compares, cycles, restore_count, toggles;

    erbc_top #(.FLASH_HALF(8), .REC_END(4)) i_erbc_top (
        .MCLK(mclk), .RSTN(rstn), .ECU_SUPPLY_ON(ecu_supply_on), .PROBE_SUPPLY_LOW(probe_supply_low),
        .TOOL_CONNECTED(tool_connected), .LINK_UP(link_up), .ECU_RESET_LINE_IN(reset_wire),
        .MCU_RESET_OUT_SENSE_N(reset_out_sense_n), .USE_RESET_OUT(use_reset_out),
        .USE_RESET_OUT_VALID(use_reset_out_valid), .USAGE_MODE(usage_mode), .INIT_DONE(init_done),
        .RESTORE_DONE(restore_done), .CAL_WRITE(cal_write), .TOOL_RESET_REQ(tool_reset_req),
        .PROBE_FAULT(probe_fault), .RECOVERY_START(recovery_start), .BOOT_CODE_LOADED(boot_code_loaded),
        .PROGRAM_DONE(program_done), .ECU_RESET_LINE_OUT(reset_drive), .ECU_RESET_LINE_OE(reset_oe),
        .BOOT_CONFIG_LINES_OUT(boot_drive), .BOOT_CONFIG_LINES_OE(boot_oe),
        .RESET_CONFIG_STROBE_OUT(strobe_drive), .RESET_CONFIG_STROBE_OE(strobe_oe),
        .WRITE_PROTECT(write_protect), .ECU_OFF(ecu_off), .POWER_SAVE(power_save), .RESTORE_REQ(restore_req),
        .RECOVERY_ACTIVE(recovery_active), .LED_RED(led_red), .LED_GREEN(led_green), .LED_YELLOW(led_yellow)
    );

    erbc_ecu_model i_erbc_ecu_model (
        .reset_oe(reset_oe), .reset_drive(reset_drive), .boot_oe(boot_oe), .boot_drive(boot_drive),
        .strobe_oe(strobe_oe), .strobe_drive(strobe_drive), .ecu_hold(ecu_hold), .mcu_int_reset(mcu_int_reset),
        .reset_wire(reset_wire), .reset_out_sense_n(reset_out_sense_n), .latched_boot(latched_boot),
        .pll_mode(pll_mode), .probe_chip_select_a_n(cs_n)
    );

    // 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // hang guard, well above the roughly 170 cycles the sequence needs
    always @(posedge mclk) begin
        cycles++;
        restore_count += restore_req ? 1 : 0;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end

    task step(input int n);
        repeat (n) @(negedge mclk);
    endtask : step

    task check(input string what, input logic [3:0] exp, input logic [3:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one-cycle event on a sequencer input, raised at a falling edge
    task pulse(input int k);
        case (k)
            0: init_done = 1'b1;
            1: restore_done = 1'b1;
            2: cal_write = 1'b1;
            3: recovery_start = 1'b1;
            4: boot_code_loaded = 1'b1;
            default: program_done = 1'b1;
        endcase
        step(1);
        {init_done, restore_done, cal_write, recovery_start, boot_code_loaded, program_done} = 6'h00;
        step(2);
    endtask : pulse

    task conclude;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // main sequence
    initial begin
        {rstn, ecu_supply_on, probe_supply_low, tool_connected, link_up, use_reset_out} = 6'h1F;
        {use_reset_out_valid, init_done, restore_done, cal_write, tool_reset_req, probe_fault} = 6'h00;
        {recovery_start, boot_code_loaded, program_done, ecu_hold, mcu_int_reset} = 5'h00;
        usage_mode = 3'h0;
        step(20);
        check("reset oe in reset", 4'h1, reset_oe);
        check("reset data", 4'h0, reset_drive);
        check("wp in reset", 4'h1, write_protect);
        check("leds in reset", 4'h0, {led_red, led_green, led_yellow});
        check("boot oe in reset", 4'h0, {boot_oe, strobe_oe});
        rstn = 1'b1;
        step(4);
        check("red", 4'h1, led_red);
        check("yellow", 4'h1, led_yellow);
        check("ecu off", 4'h0, ecu_off);
        check("held during init", 4'h1, reset_oe);
        // restore after supply loss, mode 0
        pulse(0);
        check("restore req count", 4'h1, restore_count[3:0]);
        check("held during restore", 4'h1, reset_oe);
        probe_supply_low = 1'b0;
        pulse(1);
        check("green after restore", 4'h1, led_green);
        check("released in run", 4'h0, reset_oe);
        step(20);
        check("green stays steady", 4'h1, led_green);
        check("wp released", 4'h0, write_protect);
        pulse(2);
        check("green after new data", 4'h0, led_green);
        // reset sense source and write protect
        ecu_hold = 1'b1;
        step(6);
        check("wp from ecu reset", 4'h1, write_protect);
        ecu_hold = 1'b0;
        mcu_int_reset = 1'b1;
        step(6);
        check("option defaults off", 4'h0, write_protect);
        pulse(3);
        check("recovery refused", 4'h0, recovery_active);
        use_reset_out_valid = 1'b1;
        step(6);
        check("wp from reset out", 4'h1, write_protect);
        mcu_int_reset = 1'b0;
        step(6);
        // tool command and probe fault each pull the reset line
        for (int k = 0; k < 2; k++) begin
            {tool_reset_req, probe_fault} = k[0] ? 2'h1 : 2'h2;
            step(3);
            check("commanded reset", 4'h1, reset_oe);
            {tool_reset_req, probe_fault} = 2'h0;
            step(3);
            check("commanded release", 4'h0, reset_oe);
        end
        // recovery flashing, back-to-back steps
        pulse(3);
        check("recovery hold", 4'h3, {recovery_active, reset_oe});
        check("boot lines", {2'h2, BOOT_CFG_EXTERNAL}, {boot_oe & strobe_oe, 1'b0, boot_drive});
        check("pll pins ecu owned", 4'h1, pll_mode);
        pulse(4);
        check("released for boot", 4'h0, reset_oe);
        check("strobe low", 4'h2, {strobe_oe, strobe_drive});
        check("mcu strap", {2'h0, BOOT_CFG_EXTERNAL}, latched_boot);
        check("probe select", 4'h0, cs_n);
        pulse(5);
        check("reset again", 4'h1, reset_oe);
        check("drives released", 4'h0, {boot_oe, strobe_oe});
        step(8);
        check("recovery over", 4'h0, {recovery_active, reset_oe});
        check("internal boot", 4'h0, latched_boot);
        // ram adapter mode flashes green
        usage_mode = 3'h3;
        step(3);
        toggles = 0;
        for (int i = 0; i < 40; i++) begin
            prev = led_green;
            step(1);
            toggles += (led_green !== prev) ? 1 : 0;
        end
        check("green flashing", 4'h1, toggles >= 4 && toggles <= 6);
        usage_mode = 3'h0;
        step(3);
        check("green off mode 0", 4'h0, led_green);
        // link loss is seen only after the synchroniser
        link_up = 1'b0;
        step(1);
        check("yellow sync lag", 4'h1, led_yellow);
        step(3);
        check("yellow off", 4'h0, led_yellow);
        // tool unplugged, ecu switched off
        {tool_connected, ecu_supply_on} = 2'h0;
        step(5);
        check("power save", 4'h3, {power_save, reset_oe});
        check("ecu off seen", 4'h1, ecu_off);
        check("red off", 4'h0, led_red);
        // supply loss again, but a noinit mode skips the copy
        {probe_supply_low, usage_mode} = 4'h9;
        tool_connected = 1'b1;
        step(5);
        check("init after save", 4'h1, {power_save, reset_oe});
        pulse(0);
        check("no restore", 4'h1, restore_count[3:0]);
        check("released after init", 4'h0, reset_oe);
        conclude();
    end
endmodule : erbc_top_bench
